/* csr_regs.sv */
// Chosen here: register access over APB.
`timescale 1ns/10ps
// top: apb register bank for transmit software signaling, received line signaling and clock-recovery control
//
// Contract
// R1: each port has a read/write word of eight signaling nibbles for slots 24..31, slot 24 lowest, every 0x10 bytes.
// R2: the received line signaling region is decoded from base 0x40000.
// R3: received line signaling words are read-only and show the nibbles being driven out on tdm_out_signaling; here they show line_nibble from the packet engine.
// R4: any change of a received nibble raises the interrupt request; here only for ports whose mask bit is set, and the mask resets to 0x00.
// R5: a change sets the per-slot change bit naming exactly which slots changed.
// R6: the word for a port and slot sits at 0x80*(port-1)+slot*4, up to 0x3FC.
// R7: each received word holds ABCD in bits 3:0 and zeros in bits 31:4.
// R8: words are indexed by slot 0..31 and port 1..8.
// R9: the clock-recovery region starts at 0x48000, one control word per port every 0x400, then forty config words.
// R10: writing 1 to control bit 0 pulses that port's recovery reset; the bit is write-only and resets to zero.
// R11: software writes the upper control bits only with vendor-prescribed values.
// R12: software programs the delay variation tolerance before relying on recovery.
// R13: bundles selecting software source send the written nibbles instead of tdm_in_signaling.
// R14: reserved bits read as zero and writes to them have no effect.
module csr_regs
  import csr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received signaling from the packet engine
  input wire logic line_valid,
  input wire logic [2:0] line_port,
  input wire logic [4:0] line_slot,
  input wire logic [3:0] line_nibble,
  // transmit signaling path: per port slot 24..31 nibbles and source choice
  input wire logic [CSR_PORTS-1:0] soft_source_sel,
  input wire logic [2:0] tx_port,
  input wire logic [2:0] tx_slot_hi,
  input wire logic [3:0] tdm_in_signaling,
  output logic [3:0] tx_signal_nibble,
  output logic [3:0] tdm_out_signaling,
  output logic [CSR_PORTS-1:0] recovery_reset,
  output logic irq
);
  typedef struct packed {
    logic [CSR_PORTS-1:0][31:0] tx_soft;
    logic [7:0] mask;
    logic [CSR_PORTS-1:0] recovery_reset;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rd_pending;
    logic [7:0] last_addr;
    logic [3:0] tx_signal_nibble;
    logic [3:0] tdm_out_signaling;
    logic irq;
  } csr_state_t;
  csr_state_t state;
  csr_state_t next_state;

  csr_sel_t sel;
  logic [2:0] sel_port;
  logic [4:0] sel_slot;
  logic [19:0] rel;
  logic [7:0] mem_rd_addr;
  logic [3:0] mem_rd_data;
  logic mem_changed;
  logic [CSR_PORTS-1:0][31:0] chg_set;
  logic [CSR_PORTS-1:0][31:0] chg_clr;
  logic [CSR_PORTS-1:0][31:0] chg_flags;
  logic [7:0] port_pending;
  logic [7:0] line_addr;
  logic access;
  logic hit_tx;
  logic hit_rx;
  logic hit_cr;
  logic hit_chg;
  logic hit_mask;
  logic hit_sum;
  logic wr_access;
  logic rd_access;
  logic rd_slow;
  logic [31:0] rd_value;
  logic [31:0] tx_word;
  logic [3:0] tx_nibble;

  // region hits of the byte address; upper bounds exclusive except for the last received word
  assign hit_tx = paddr >= CSR_TX_SOFT_BASE && paddr < CSR_TX_SOFT_BASE + CSR_TX_SOFT_STRIDE * 20'(CSR_PORTS);
  assign hit_rx = paddr >= CSR_RX_LINE_BASE && paddr <= CSR_RX_LINE_BASE + CSR_RX_LINE_LAST;
  assign hit_cr = paddr >= CSR_CLKREC_BASE && paddr < CSR_CLKREC_BASE + CSR_CLKREC_STRIDE * 20'(CSR_PORTS);
  // change flag words, one per port, then mask and summary words
  assign hit_chg = paddr >= CSR_IRQ_BASE && paddr < CSR_IRQ_BASE + 20'(4 * CSR_PORTS);
  assign hit_mask = paddr == CSR_IRQ_BASE + CSR_IRQ_MASK_OFS;
  assign hit_sum = paddr == CSR_IRQ_BASE + CSR_IRQ_SUM_OFS;

  // address decode of the four regions
  always_comb
  begin
    sel = CSR_SEL_NONE;
    sel_port = 3'h0;
    sel_slot = 5'h00;
    rel = 20'h00000;
    if (paddr[1:0] == 2'h0)
    begin
      if (hit_tx)
      begin
        rel = paddr - CSR_TX_SOFT_BASE;
        sel_port = rel[6:4];
        // R1: only the slot 24..31 word is held here
        if (rel[3:0] == CSR_TX_SOFT_HI_OFS[3:0])
          sel = CSR_SEL_TX;
      end
      // R2: received region base
      else if (hit_rx)
      begin
        rel = paddr - CSR_RX_LINE_BASE;
        // R6: port stride 0x80, slot stride 4
        // R8: port index 1..8 maps to 0..7, slot 0..31
        sel_port = rel[9:7];
        sel_slot = rel[6:2];
        sel = CSR_SEL_RX;
      end
      // R9: clock-recovery region, control word per port then config block
      else if (hit_cr)
      begin
        rel = paddr - CSR_CLKREC_BASE;
        sel_port = rel[12:10];
        if (rel[9:0] == 10'h000)
          sel = CSR_SEL_CR;
        else if (rel[9:0] <= CSR_CLKREC_CFG_LAST[9:0])
          sel = CSR_SEL_CFG;
      end
      else if (hit_chg)
      begin
        rel = paddr - CSR_IRQ_BASE;
        sel_port = rel[4:2];
        sel = CSR_SEL_CHG;
      end
      else if (hit_mask)
        sel = CSR_SEL_MASK;
      else if (hit_sum)
        sel = CSR_SEL_SUM;
    end
  end

  assign mem_rd_addr = {sel_port, sel_slot};
  assign line_addr = {line_port, line_slot};
  assign access = psel && penable && !state.pready;

  // R3: received nibbles stored only from the packet engine, never from the bus
  csr_line_mem u_line_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(line_valid),
    .wr_addr(line_addr),
    .wr_data(line_nibble),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data),
    .changed(mem_changed)
  );

  // change set and write-one-to-clear terms per port; the change flag lags the memory write by one
  // cycle, so the slot is taken from the registered copy of the write address
  always_comb
  begin
    for (int p = 0; p < CSR_PORTS; p++)
    begin
      chg_set[p] = 32'h0000_0000;
      chg_clr[p] = 32'h0000_0000;
      // R5: mark exactly the slot whose nibble changed
      if (mem_changed && state.last_addr[7:5] == 3'(p))
        chg_set[p][state.last_addr[4:0]] = 1'b1;
      if (wr_access && sel == CSR_SEL_CHG && sel_port == 3'(p))
        chg_clr[p] = pwdata;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < CSR_PORTS; gp++)
    begin : g_chg
      csr_sticky_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(chg_set[gp]),
        .clear_bits(chg_clr[gp]),
        .flags(chg_flags[gp])
      );
    end
  endgenerate

  always_comb
  begin
    for (int p = 0; p < CSR_PORTS; p++)
      port_pending[p] = |chg_flags[p];
  end

  // access strobes; a read of the received memory waits one cycle for its registered data
  assign wr_access = access && pwrite;
  assign rd_access = access && !pwrite;
  assign rd_slow = rd_access && sel == CSR_SEL_RX && !state.rd_pending;

  // read data of every region, taken into prdata together with pready
  always_comb
  begin
    case (sel)
      CSR_SEL_TX:
        rd_value = state.tx_soft[sel_port];
      // R7: nibble in bits 3:0, zeros above
      CSR_SEL_RX:
        rd_value = {28'h0000000, mem_rd_data};
      CSR_SEL_CHG:
        rd_value = chg_flags[sel_port];
      CSR_SEL_MASK:
        rd_value = {24'h000000, state.mask};
      CSR_SEL_SUM:
        rd_value = {24'h000000, port_pending};
      // R10: the control word is write-only and reads zero
      // R14: config block and reserved bits read zero
      default:
        rd_value = CSR_ZERO;
    endcase
  end

  // software word and nibble picked by the transmit side
  assign tx_word = state.tx_soft[tx_port];
  assign tx_nibble = tx_word[tx_slot_hi*CSR_NIB_W +: CSR_NIB_W];

  // bus, register and output update
  always_comb
  begin
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    next_state.recovery_reset = '0;
    next_state.rd_pending = 1'b0;
    next_state.last_addr = line_addr;
    if (rd_slow)
    begin
      // hold off pready until the memory word is registered
      next_state.rd_pending = 1'b1;
    end
    else if (access)
    begin
      // every other access is answered at once; unmapped or unaligned words raise pslverr
      next_state.pready = 1'b1;
      next_state.pslverr = (sel == CSR_SEL_NONE);
      if (wr_access)
        next_state.prdata = CSR_ZERO;
      else
        next_state.prdata = rd_value;
    end
    if (wr_access)
    begin
      case (sel)
        CSR_SEL_TX:
        begin
          // R1: byte lanes honoured on the read/write signaling word
          for (int b = 0; b < 4; b++)
            if (pstrb[b])
              next_state.tx_soft[sel_port][b*8 +: 8] = pwdata[b*8 +: 8];
        end
        CSR_SEL_CR:
        begin
          // R10: write one pulses the port's recovery reset
          // R14: upper control bits stored nowhere
          if (pstrb[0] && pwdata[CSR_RECOVERY_RESET_BIT])
            next_state.recovery_reset[sel_port] = 1'b1;
        end
        CSR_SEL_MASK:
        begin
          if (pstrb[0])
            next_state.mask = pwdata[7:0];
        end
        // R3: writes to the received words are ignored
        default:
        begin
        end
      endcase
    end
    // R13: software nibbles replace the sampled input for software-source bundles
    next_state.tx_signal_nibble = tx_nibble;
    if (soft_source_sel[tx_port])
      next_state.tdm_out_signaling = tx_nibble;
    else
      next_state.tdm_out_signaling = tdm_in_signaling;
    // R4: level interrupt while an unmasked port has a change
    next_state.irq = |(port_pending & state.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '0;
      state.mask <= CSR_IRQ_MASK_RESET;
    end
    else
      state <= next_state;
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign recovery_reset = state.recovery_reset;
  assign tx_signal_nibble = state.tx_signal_nibble;
  assign tdm_out_signaling = state.tdm_out_signaling;
  assign irq = state.irq;
endmodule // csr_regs

/* csr_pkg.sv */
// package: address map, field layout and constants of the signaling and clock-recovery register bank
package csr_pkg;
  localparam int unsigned CSR_PORTS = 8;
  localparam int unsigned CSR_SLOTS = 32;
  localparam int unsigned CSR_AW = 20;
  // region bases within the block address space
  localparam logic [19:0] CSR_TX_SOFT_BASE = 20'h38000;
  localparam logic [19:0] CSR_RX_LINE_BASE = 20'h40000;
  localparam logic [19:0] CSR_CLKREC_BASE = 20'h48000;
  // per-port strides and word offsets
  localparam logic [19:0] CSR_TX_SOFT_STRIDE = 20'h00010;
  localparam logic [19:0] CSR_TX_SOFT_HI_OFS = 20'h0000C;
  localparam logic [19:0] CSR_RX_LINE_STRIDE = 20'h00080;
  localparam logic [19:0] CSR_RX_LINE_LAST = 20'h003FC;
  localparam logic [19:0] CSR_CLKREC_STRIDE = 20'h00400;
  localparam logic [19:0] CSR_CLKREC_CFG_LAST = 20'h000A0;
  // interrupt block registers (own placement)
  localparam logic [19:0] CSR_IRQ_BASE = 20'h4F000;
  localparam logic [19:0] CSR_IRQ_MASK_OFS = 20'h00020;
  localparam logic [19:0] CSR_IRQ_SUM_OFS = 20'h00040;
  // field layout
  localparam int unsigned CSR_NIB_W = 4;
  localparam int unsigned CSR_RECOVERY_RESET_BIT = 0;
  localparam logic [31:0] CSR_ZERO = 32'h0000_0000;
  localparam logic [31:0] CSR_TX_SOFT_RESET = 32'h0000_0000;
  localparam logic [7:0] CSR_IRQ_MASK_RESET = 8'h00;
  // region select
  typedef enum logic [2:0] {CSR_SEL_NONE, CSR_SEL_TX, CSR_SEL_RX, CSR_SEL_CR, CSR_SEL_CFG,
    CSR_SEL_CHG, CSR_SEL_MASK, CSR_SEL_SUM} csr_sel_t;
endpackage

/* csr_line_mem.sv */
`timescale 1ns/10ps
// memory of received signaling nibbles per port and timeslot, with change detection
module csr_line_mem
  import csr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [3:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [3:0] rd_data,
  output logic changed
);
  typedef struct packed {
    logic [CSR_PORTS*CSR_SLOTS-1:0][3:0] mem;
    logic [3:0] rd_data;
    logic changed;
  } csr_mem_state_t;
  csr_mem_state_t state;
  csr_mem_state_t next_state;

  // write new nibble, flag difference, registered read
  always_comb
  begin
    next_state = state;
    next_state.changed = 1'b0;
    if (wr_en)
    begin
      next_state.changed = (state.mem[wr_addr] != wr_data);
      next_state.mem[wr_addr] = wr_data;
    end
    next_state.rd_data = state.mem[rd_addr];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign rd_data = state.rd_data;
  assign changed = state.changed;
endmodule // csr_line_mem

/* csr_sticky_bank.sv */
`timescale 1ns/10ps
// one port's 32 sticky change bits, set by hardware, cleared by write-one
module csr_sticky_bank
  import csr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] set_bits,
  input wire logic [31:0] clear_bits,
  output logic [31:0] flags
);
  typedef struct packed {
    logic [31:0] flags;
  } csr_sticky_state_t;
  csr_sticky_state_t state;
  csr_sticky_state_t next_state;

  // set wins over a clear in the same cycle
  always_comb
  begin
    next_state = state;
    next_state.flags = (state.flags & ~clear_bits) | set_bits;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign flags = state.flags;
endmodule // csr_sticky_bank

/* csr_regs_monitor.sv */
// checker: port-level properties of the signaling register bank
`timescale 1ns/10ps
module csr_regs_monitor
  import csr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CSR_PORTS-1:0] soft_source_sel,
  input wire logic [2:0] tx_port,
  input wire logic [3:0] tdm_in_signaling,
  input wire logic [3:0] tx_signal_nibble,
  input wire logic [3:0] tdm_out_signaling,
  input wire logic [CSR_PORTS-1:0] recovery_reset,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rx_a;
  logic cr_a;
  // region decodes: received words and per-port control words
  assign rx_a = paddr[19:10] == 10'h100 && paddr[1:0] == 2'h0;
  assign cr_a = paddr[19:13] == 7'h24 && paddr[9:0] == 10'h000;
  property p_rx_upper_zero;
    pready && !pwrite && rx_a |-> prdata[31:4] == 28'h0000000;
  endproperty
  a_rx_upper_zero: assert property (p_rx_upper_zero)
    else $error("received word upper bits not zero");
  property p_rx_write_quiet;
    pready && pwrite && rx_a |-> !pslverr;
  endproperty
  a_rx_write_quiet: assert property (p_rx_write_quiet)
    else $error("write to received word flagged");
  property p_rx_latency;
    psel && penable && !$past(penable) && !pwrite && rx_a |-> ##1 !pready ##1 pready;
  endproperty
  a_rx_latency: assert property (p_rx_latency)
    else $error("received region read latency wrong");
  property p_ctrl_read_zero;
    pready && !pwrite && cr_a |-> prdata == 32'h0000_0000;
  endproperty
  a_ctrl_read_zero: assert property (p_ctrl_read_zero)
    else $error("control word read not zero");
  property p_rst_cause;
    |recovery_reset |-> pready && pwrite && pwdata[0] && cr_a && $onehot(recovery_reset);
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("recovery reset without control write");
  property p_rst_pulse;
    |recovery_reset |=> recovery_reset == 8'h00;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("recovery reset longer than one cycle");
  property p_line_path;
    !soft_source_sel[tx_port] |=> tdm_out_signaling == $past(tdm_in_signaling);
  endproperty
  a_line_path: assert property (p_line_path)
    else $error("input signaling not passed through");
  property p_soft_path;
    soft_source_sel[tx_port] |=> tdm_out_signaling == tx_signal_nibble;
  endproperty
  a_soft_path: assert property (p_soft_path)
    else $error("software nibble not sent");
  property p_irq_fall;
    $fell(irq) |-> $past(pwrite && pready) || $past(pwrite && pready, 2) || $past(pwrite && pready, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
endmodule // csr_regs_monitor

/* tb.sv */
// testbench: apb sequences against the signaling register bank
`timescale 1ns/10ps
module tb;
  import csr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, line_valid = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF, line_nibble = 4'h0, tdm_in_signaling = 4'h5, tx_signal_nibble, tdm_out_signaling;
  logic [2:0] line_port = 3'h0, tx_port = 3'h0, tx_slot_hi = 3'h0;
  logic [4:0] line_slot = 5'h00;
  logic [7:0] soft_source_sel = 8'h00, recovery_reset, rs;
  logic pready, pslverr, irq, er;
  int failures = 0, n_compared = 0, cycles = 0;
  csr_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .line_valid, .line_port, .line_slot, .line_nibble, .soft_source_sel, .tx_port, .tx_slot_hi,
    .tdm_in_signaling, .tx_signal_nibble, .tdm_out_signaling, .recovery_reset, .irq);
  // clock, 5 ns period
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    if (s !== e)
      failures++;
  endtask
  // one apb transfer; read data, error and reset pulses taken at the ready edge
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    rs = recovery_reset;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [19:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, x});
  endtask
  // one received nibble from the packet engine, then let the change settle
  task automatic line(input logic [2:0] p, input logic [4:0] s, input logic [3:0] n);
    @(posedge pclk);
    line_port <= p;
    line_slot <= s;
    line_nibble <= n;
    line_valid <= 1'b1;
    @(posedge pclk);
    line_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(20'h3800C, 32'h0000_0000, 1'b0);
    rchk(20'h403FC, 32'h0000_0000, 1'b0);
    rchk(20'h48000, 32'h0000_0000, 1'b0);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reset values done");
    apb(1'b1, 20'h3802C, 32'h8765_4321);
    rchk(20'h3802C, 32'h8765_4321, 1'b0);
    rchk(20'h3801C, 32'h0000_0000, 1'b0);
    rchk(20'h38020, 32'h0000_0000, 1'b1);
    tx_port <= 3'h2;
    soft_source_sel <= 8'h04;
    for (int i = 0; i < 8; i++)
    begin
      tx_slot_hi <= 3'(i);
      repeat (2) @(posedge pclk);
      chk({28'h0, tx_signal_nibble}, 32'(i + 1));
      chk({28'h0, tdm_out_signaling}, 32'(i + 1));
    end
    soft_source_sel <= 8'h00;
    repeat (2) @(posedge pclk);
    chk({28'h0, tdm_out_signaling}, 32'h0000_0005);
    pstrb <= 4'h1;
    apb(1'b1, 20'h3802C, 32'hFFFF_FFF0);
    pstrb <= 4'hF;
    rchk(20'h3802C, 32'h8765_43F0, 1'b0);
    $display("test transmit word done");
    apb(1'b1, 20'h4F020, 32'h0000_00FF);
    line(3'h7, 5'h1F, 4'hA);
    rchk(20'h403FC, 32'h0000_000A, 1'b0);
    rchk(20'h40000, 32'h0000_0000, 1'b0);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(20'h4F01C, 32'h8000_0000, 1'b0);
    rchk(20'h4F040, 32'h0000_0080, 1'b0);
    apb(1'b1, 20'h403FC, 32'hFFFF_FFFF);
    rchk(20'h403FC, 32'h0000_000A, 1'b0);
    apb(1'b1, 20'h4F01C, 32'h8000_0000);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    line(3'h7, 5'h1F, 4'hA);
    rchk(20'h4F01C, 32'h0000_0000, 1'b0);
    apb(1'b1, 20'h4F020, 32'h0000_0000);
    line(3'h0, 5'h00, 4'h3);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(20'h4F000, 32'h0000_0001, 1'b0);
    rchk(20'h40000, 32'h0000_0003, 1'b0);
    apb(1'b1, 20'h4F020, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("test line signaling done");
    // delay variation tolerance is set up outside this bank before recovery is relied on
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, 20'h48000 + 20'(k * 1024), 32'h0000_0001);
      chk({24'h0, rs}, 32'(1 << k));
    end
    apb(1'b1, 20'h48400, 32'hFFFF_FFFE);
    chk({24'h0, rs}, 32'h0000_0000);
    rchk(20'h48004, 32'h0000_0000, 1'b0);
    rchk(20'h60000, 32'h0000_0000, 1'b1);
    rchk(20'h40002, 32'h0000_0000, 1'b1);
    $display("test clock recovery done");
    stop_test();
  end
endmodule // tb
bind csr_regs csr_regs_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .soft_source_sel, .tx_port, .tdm_in_signaling, .tx_signal_nibble, .tdm_out_signaling,
  .recovery_reset, .irq);
